// [rtl/l2_lockdown_ctrl.sv]
`timescale 1ns/1ns
`include "lockdown_map.svh"

module l2_lockdown_ctrl (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RESET,
  input  wire logic                  PERMIT_WE,
  input  wire logic                  PERMIT_VAL,
  output logic                       NS_PERMIT,
  input  wire logic                  ACC_VALID,
  input  wire logic                  ACC_WRITE,
  input  wire logic                  ACC_SECURE,
  input  wire logic [11:0]           ACC_ADDR,
  input  wire logic [15:0]           ACC_WDATA,
  output logic                       ACC_DONE,
  output logic      [1:0]            ACC_RESP,
  output logic      [15:0]           ACC_RDATA,
  input  wire logic                  ALLOC_REQ,
  input  wire logic                  ALLOC_IS_INSTR,
  input  wire logic [2:0]            ALLOC_MASTER,
  input  wire logic [`SET_BITS-1:0]  ALLOC_SET,
  output logic                       ALLOC_READY,
  output logic                       ALLOC_DONE,
  output logic                       ALLOC_OK,
  output logic      [2:0]            ALLOC_WAY,
  input  wire logic                  MAINT_REQ,
  input  wire logic [1:0]            MAINT_OP,
  input  wire logic                  MAINT_BG,
  input  wire logic                  LINE_VALID,
  input  wire logic                  LINE_DIRTY,
  output logic                       MAINT_DONE,
  output logic      [1:0]            MAINT_RESP,
  output logic                       MAINT_WB,
  output logic                       MAINT_VALID_OUT,
  output logic                       MAINT_DIRTY_OUT,
  output logic                       UNLOCK_BUSY
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // First candidate way at or after the round-robin pointer, wrapping past way 7
  function automatic logic [2:0] pick_way(input logic [`WAYS-1:0] cand,
                                          input logic [2:0] ptr);
    logic [2:0] w;
    logic [2:0] res;
    res = ptr;
    for (int i = `WAYS - 1; i >= 0; i--) begin
      w = ptr + 3'(i);
      if (cand[w]) begin
        res = w;
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  lockdown_pkg::ctl_state_t state_ff;
  lockdown_pkg::ctl_state_t nxt_state;
  logic [`WAYS-1:0]     dlock_ff [0:7];
  logic [`WAYS-1:0]     ilock_ff [0:7];
  logic                 line_en_ff;
  logic [`WAYS-1:0]     unlock_mask_ff;
  logic [`SET_BITS-1:0] cnt_ff;
  logic [`SET_BITS-1:0] wr_set_ff;
  logic                 pend_ff;
  logic                 a_instr_ff;
  logic [2:0]           a_master_ff;
  logic [`SET_BITS-1:0] a_set_ff;
  logic [2:0]           rr_ff;
  logic [`WAYS-1:0]     mem_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Register access decode

  wire        in_lock  = (ACC_ADDR >= `OFF_LOCK_BASE) &&
                         (ACC_ADDR <= `OFF_LOCK_LAST) &&
                         (ACC_ADDR[1:0] == 2'h0);
  wire        in_len   = (ACC_ADDR == `OFF_LINE_EN);
  wire        in_unl   = (ACC_ADDR == `OFF_UNLOCK_ALL);
  wire        mapped   = in_lock || in_len || in_unl;
  wire [2:0]  r_master = ACC_ADDR[5:3];
  wire        r_instr  = ACC_ADDR[2];
  // Pairs beyond the first are dead without the by-master option
  wire        r_used   = `LOCK_BY_MASTER || (r_master == 3'h0);
  // Non-secure write needs the permit; secure always passes
  wire        wr_allow = ACC_SECURE || NS_PERMIT;
  wire        wr_refuse = ACC_VALID && ACC_WRITE && mapped &&
                          !wr_allow;
  wire        wr_do    = ACC_VALID && ACC_WRITE && mapped &&
                         wr_allow;
  wire [`WAYS-1:0] wdat = ACC_WDATA[`WAYS-1:0];

  // Read data; reserved upper bits and unused pairs read as zero
  wire [`WAYS-1:0] lock_rd = !r_used ? `LOCK_RST :
                             r_instr ? ilock_ff[r_master] :
                             dlock_ff[r_master];
  wire [15:0] rd_val = in_lock ? {8'h00, lock_rd} :
                       in_len  ? {15'h0000, line_en_ff} :
                       in_unl  ? {8'h00, unlock_mask_ff} :
                       16'h0000;
  wire [1:0]  resp   = !mapped   ? `RESP_DECERR :
                       wr_refuse ? `RESP_DECERR :
                       `RESP_OKAY;

  // Accept a new unlock-all only when idle; a busy one is left running
  wire start_unl = wr_do && in_unl && (wdat != 8'h00) &&
                   (state_ff == lockdown_pkg::ST_IDLE);

  // Permit bit: written only through the secure auxiliary path
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      NS_PERMIT <= `PERMIT_RST;
    end else if (PERMIT_WE) begin
      NS_PERMIT <= PERMIT_VAL;
    end
  end

  // Lock registers; refused writes leave them untouched
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      for (int m = 0; m < 8; m++) begin
        dlock_ff[m] <= `LOCK_RST;
        ilock_ff[m] <= `LOCK_RST;
      end
      line_en_ff <= 1'b0;
    end else if (wr_do && in_lock && r_used) begin
      if (r_instr) begin
        ilock_ff[r_master] <= wdat;
      end else begin
        dlock_ff[r_master] <= wdat;
      end
    end else if (wr_do && in_len) begin
      line_en_ff <= ACC_WDATA[`LINE_EN_BIT];
    end
  end

  // Access response, one cycle after the request
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ACC_DONE  <= 1'b0;
      ACC_RESP  <= `RESP_OKAY;
      ACC_RDATA <= 16'h0000;
    end else begin
      ACC_DONE  <= ACC_VALID;
      ACC_RESP  <= resp;
      ACC_RDATA <= (ACC_VALID && !ACC_WRITE) ? rd_val : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Allocation and unlock-all sequencing

  wire [2:0]       eff_master = `LOCK_BY_MASTER ? a_master_ff : 3'h0;
  wire [`WAYS-1:0] way_lock   = a_instr_ff ? ilock_ff[eff_master] :
                                dlock_ff[eff_master];
  // Way and line locks both remove a way from the candidates
  wire [`WAYS-1:0] cand       = ~(way_lock | mem_rd);
  wire             any_cand   = |cand;
  wire [2:0]       victim     = pick_way(cand, rr_ff);
  wire [`WAYS-1:0] victim_bit = `WAYS'(1) << victim;

  wire             alloc_wr = (state_ff == lockdown_pkg::ST_ALOOK) &&
                              any_cand && line_en_ff;
  wire             unl_wr   = ((state_ff == lockdown_pkg::ST_UNLOCK) &&
                               pend_ff) ||
                              (state_ff == lockdown_pkg::ST_UFLUSH);
  wire             mem_we   = alloc_wr || unl_wr;
  wire [`SET_BITS-1:0] mem_wa = alloc_wr ? a_set_ff : wr_set_ff;
  wire [`WAYS-1:0] mem_wd   = alloc_wr ? (mem_rd | victim_bit) :
                              (mem_rd & ~unlock_mask_ff);
  wire [`SET_BITS-1:0] mem_ra = (state_ff == lockdown_pkg::ST_IDLE) ?
                                ALLOC_SET : cnt_ff;

  line_lock_mem u_mem (
    .clk     (CLK_SYS),
    .rd_addr (mem_ra),
    .rd_data (mem_rd),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (mem_wd)
  );

  // Next state; unlock-all takes priority over a fresh allocation
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      lockdown_pkg::ST_IDLE: begin
        if (start_unl) begin
          nxt_state = lockdown_pkg::ST_UNLOCK;
        end else if (ALLOC_REQ) begin
          nxt_state = lockdown_pkg::ST_ALOOK;
        end
      end
      lockdown_pkg::ST_ALOOK: begin
        nxt_state = lockdown_pkg::ST_IDLE;
      end
      lockdown_pkg::ST_UNLOCK: begin
        if (cnt_ff == `LAST_SET) begin
          nxt_state = lockdown_pkg::ST_UFLUSH;
        end
      end
      default: begin
        nxt_state = lockdown_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state_ff       <= lockdown_pkg::ST_IDLE;
      unlock_mask_ff <= `LOCK_RST;
      cnt_ff         <= '0;
      wr_set_ff      <= '0;
      pend_ff        <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (start_unl) begin
        unlock_mask_ff <= wdat;
        cnt_ff         <= '0;
        pend_ff        <= 1'b0;
      end else if (state_ff == lockdown_pkg::ST_UNLOCK) begin
        wr_set_ff <= cnt_ff;
        cnt_ff    <= cnt_ff + 1'b1;
        pend_ff   <= 1'b1;
      end else if (state_ff == lockdown_pkg::ST_UFLUSH) begin
        unlock_mask_ff <= `LOCK_RST;
        pend_ff        <= 1'b0;
      end
    end
  end

  // Allocation request capture and registered answer
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      a_instr_ff  <= 1'b0;
      a_master_ff <= 3'h0;
      a_set_ff    <= '0;
      rr_ff       <= 3'h0;
      ALLOC_READY <= 1'b0;
      ALLOC_DONE  <= 1'b0;
      ALLOC_OK    <= 1'b0;
      ALLOC_WAY   <= 3'h0;
      UNLOCK_BUSY <= 1'b0;
    end else begin
      ALLOC_READY <= (nxt_state == lockdown_pkg::ST_IDLE) && !start_unl;
      UNLOCK_BUSY <= (nxt_state == lockdown_pkg::ST_UNLOCK) ||
                     (nxt_state == lockdown_pkg::ST_UFLUSH);
      ALLOC_DONE  <= (state_ff == lockdown_pkg::ST_ALOOK);
      if (nxt_state == lockdown_pkg::ST_ALOOK) begin
        a_instr_ff  <= ALLOC_IS_INSTR;
        a_master_ff <= ALLOC_MASTER;
        a_set_ff    <= ALLOC_SET;
      end
      if (state_ff == lockdown_pkg::ST_ALOOK) begin
        // No free way means the fill is refused, not forced in
        ALLOC_OK  <= any_cand;
        ALLOC_WAY <= victim;
        if (any_cand) begin
          rr_ff <= victim + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line maintenance: lock state is deliberately not consulted

  wire maint_refuse = MAINT_BG && UNLOCK_BUSY;
  wire wb_need      = LINE_VALID && LINE_DIRTY;

  // New line state per operation
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      MAINT_DONE      <= 1'b0;
      MAINT_RESP      <= `RESP_OKAY;
      MAINT_WB        <= 1'b0;
      MAINT_VALID_OUT <= 1'b0;
      MAINT_DIRTY_OUT <= 1'b0;
    end else begin
      MAINT_DONE      <= MAINT_REQ;
      MAINT_RESP      <= maint_refuse ? `RESP_SLVERR : `RESP_OKAY;
      MAINT_WB        <= 1'b0;
      MAINT_VALID_OUT <= LINE_VALID;
      MAINT_DIRTY_OUT <= LINE_DIRTY;
      if (MAINT_REQ && !maint_refuse) begin
        case (lockdown_pkg::maint_op_t'(MAINT_OP))
          lockdown_pkg::OP_CLEAN: begin
            MAINT_WB        <= wb_need;
            MAINT_DIRTY_OUT <= 1'b0;
          end
          lockdown_pkg::OP_INVALIDATE: begin
            MAINT_VALID_OUT <= 1'b0;
            MAINT_DIRTY_OUT <= 1'b0;
          end
          lockdown_pkg::OP_CLEAN_INV: begin
            MAINT_WB        <= wb_need;
            MAINT_VALID_OUT <= 1'b0;
            MAINT_DIRTY_OUT <= 1'b0;
          end
          default: begin
            MAINT_WB <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // l2_lockdown_ctrl

// [rtl/lockdown_map.svh]
`ifndef LOCKDOWN_MAP_SVH
`define LOCKDOWN_MAP_SVH

// Register offsets on the lockdown access port (byte addresses)
`define OFF_LOCK_BASE    12'h900
`define OFF_LOCK_LAST    12'h93c
`define OFF_LINE_EN      12'h950
`define OFF_UNLOCK_ALL   12'h954

// Field layout
`define WAYS             8
`define SET_BITS         6
`define LAST_SET         6'h3f
`define LINE_EN_BIT      0

// Reset values
`define LOCK_RST         8'h00
`define PERMIT_RST       1'b0

// Option: lockdown by master; 0 means only the first pair is used
`define LOCK_BY_MASTER   1'b0

// Response codes
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`define RESP_DECERR      2'h3

`endif

// [rtl/lockdown_pkg.sv]
package lockdown_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ALOOK,
    ST_UNLOCK,
    ST_UFLUSH
  } ctl_state_t;

  typedef enum logic [1:0] {
    OP_CLEAN,
    OP_INVALIDATE,
    OP_CLEAN_INV,
    OP_NONE
  } maint_op_t;

endpackage

// [rtl/line_lock_mem.sv]
`timescale 1ns/1ns
`include "lockdown_map.svh"

// Per-set line lock bits, one bit per way; read data is registered
module line_lock_mem (
  input  wire logic                   clk,
  input  wire logic [`SET_BITS-1:0]   rd_addr,
  output logic      [`WAYS-1:0]       rd_data,
  input  wire logic                   wr_en,
  input  wire logic [`SET_BITS-1:0]   wr_addr,
  input  wire logic [`WAYS-1:0]       wr_data
);

  logic [`WAYS-1:0] mem [0:(1<<`SET_BITS)-1];

  // No reset on the array; software unlocks all lines before use
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // line_lock_mem

// [tb/lockdown_properties.sv]
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Watches the lockdown controller's ports only
module lockdown_checker (
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  input wire logic        PERMIT_WE,
  input wire logic        PERMIT_VAL,
  input wire logic        NS_PERMIT,
  input wire logic        ACC_VALID,
  input wire logic        ACC_WRITE,
  input wire logic        ACC_SECURE,
  input wire logic [11:0] ACC_ADDR,
  input wire logic        ACC_DONE,
  input wire logic [1:0]  ACC_RESP,
  input wire logic        ALLOC_REQ,
  input wire logic        ALLOC_READY,
  input wire logic        ALLOC_DONE,
  input wire logic        MAINT_REQ,
  input wire logic [1:0]  MAINT_OP,
  input wire logic        MAINT_BG,
  input wire logic        LINE_VALID,
  input wire logic        LINE_DIRTY,
  input wire logic        MAINT_DONE,
  input wire logic [1:0]  MAINT_RESP,
  input wire logic        MAINT_WB,
  input wire logic        MAINT_VALID_OUT,
  input wire logic        MAINT_DIRTY_OUT,
  input wire logic        UNLOCK_BUSY
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // Decodes of the first lock pair and of any write to the unlock-all register
  wire lock_hit = ACC_ADDR == 12'h900 || ACC_ADDR == 12'h904;
  wire ns_wr    = ACC_VALID && ACC_WRITE && !ACC_SECURE && lock_hit;
  wire unl_wr   = ACC_VALID && ACC_WRITE && ACC_ADDR == 12'h954;
  wire bg_busy  = MAINT_REQ && MAINT_BG && UNLOCK_BUSY;
  a_access_answer: assert property (ACC_VALID |=> ACC_DONE)
    else $error("access not answered");
  a_ns_refused: assert property (ns_wr && !NS_PERMIT |=> ACC_RESP == 2'h3)
    else $error("refused write lacks decode error");
  a_ns_allowed: assert property (ns_wr && NS_PERMIT |=> ACC_RESP == 2'h0)
    else $error("permitted write not okay");
  a_secure_write: assert property (ACC_VALID && ACC_WRITE && ACC_SECURE && lock_hit
    |=> ACC_RESP == 2'h0) else $error("secure write not okay");
  a_read_okay: assert property (ACC_VALID && !ACC_WRITE && lock_hit
    |=> ACC_RESP == 2'h0) else $error("read not okay");
  a_permit_reset: assert property ($fell(RESET) |-> !NS_PERMIT)
    else $error("permit bit set after reset");
  a_permit_write: assert property (PERMIT_WE |=> NS_PERMIT == $past(PERMIT_VAL))
    else $error("permit bit not written");
  a_bg_refused: assert property (bg_busy
    |=> MAINT_DONE && MAINT_RESP == 2'h2 && !MAINT_WB) else $error("no slave error");
  a_clean_inv: assert property (MAINT_REQ && MAINT_OP == 2'h2 && !bg_busy
    |=> MAINT_WB == ($past(LINE_VALID) && $past(LINE_DIRTY)) && !MAINT_VALID_OUT
    && !MAINT_DIRTY_OUT) else $error("clean-invalidate result wrong");
  a_line_invalidate: assert property (MAINT_REQ && MAINT_OP == 2'h1 && !bg_busy
    |=> !MAINT_WB && !MAINT_VALID_OUT && !MAINT_DIRTY_OUT)
    else $error("invalidate result wrong");
  a_alloc_answer: assert property (ALLOC_REQ && ALLOC_READY && !unl_wr
    |=> !ALLOC_READY ##1 ALLOC_DONE) else $error("allocation not answered");
  c_ns_refused: cover property (ns_wr && !NS_PERMIT);
  c_bg_busy: cover property (bg_busy);
  c_alloc: cover property (ALLOC_DONE);
endmodule // lockdown_checker

// [tb/host_model.sv]
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Register-access master; one-cycle request, answer sampled a cycle later
module host_model (
  input  wire logic        clk,
  output logic             valid,
  output logic             write,
  output logic             secure,
  output logic [11:0]      addr,
  output logic [15:0]      wdata,
  input  wire logic        done,
  input  wire logic [1:0]  resp,
  input  wire logic [15:0] rdata
);
  initial begin
    valid = 1'b0;
    write = 1'b0;
    secure = 1'b1;
    addr = 12'h000;
    wdata = 16'h0000;
  end
  // Released bus shows inverted values so stale data never looks valid
  task automatic access(input logic w, input logic s, input logic [11:0] a,
                        input logic [15:0] d, output logic ok,
                        output logic [1:0] r, output logic [15:0] q);
    @(posedge clk);
    valid <= 1'b1;
    write <= w;
    secure <= s;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    valid <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    #1;
    ok = done;
    r = resp;
    q = rdata;
  endtask
endmodule // host_model

// [tb/tb.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
//////////////////////////////////////////////////////////////////////////////
module tb;
  logic        clk_sys, reset, pwe, pval, areq, ainstr, mreq, mbg, lv, ld;
  logic [5:0]  aset;
  logic [1:0]  mop, r, aresp, mresp;
  logic [15:0] q, rdata, wdata;
  logic [11:0] addr;
  logic [2:0]  away;
  logic [7:0]  seen;
  logic        ok, nsp, av, aw, as, ad, ardy, adone, aok, mdone, wb, vo, dout;
  logic        busy;
  int          n_fail, num_checks, i;
  host_model host (.clk(clk_sys), .valid(av), .write(aw), .secure(as),
    .addr(addr), .wdata(wdata), .done(ad), .resp(aresp), .rdata(rdata));
  l2_lockdown_ctrl uut (.CLK_SYS(clk_sys), .RESET(reset), .PERMIT_WE(pwe),
    .PERMIT_VAL(pval), .NS_PERMIT(nsp), .ACC_VALID(av), .ACC_WRITE(aw),
    .ACC_SECURE(as), .ACC_ADDR(addr), .ACC_WDATA(wdata), .ACC_DONE(ad),
    .ACC_RESP(aresp), .ACC_RDATA(rdata), .ALLOC_REQ(areq),
    .ALLOC_IS_INSTR(ainstr), .ALLOC_MASTER(3'h0), .ALLOC_SET(aset),
    .ALLOC_READY(ardy), .ALLOC_DONE(adone), .ALLOC_OK(aok), .ALLOC_WAY(away),
    .MAINT_REQ(mreq), .MAINT_OP(mop), .MAINT_BG(mbg), .LINE_VALID(lv),
    .LINE_DIRTY(ld), .MAINT_DONE(mdone), .MAINT_RESP(mresp), .MAINT_WB(wb),
    .MAINT_VALID_OUT(vo), .MAINT_DIRTY_OUT(dout), .UNLOCK_BUSY(busy));
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task acc(input logic w, s, input logic [11:0] a, input logic [15:0] d);
    host.access(w, s, a, d, ok, r, q);
  endtask
  // Allocation: answer stands one edge after the taking edge
  task alloc(input logic instr, input logic [5:0] set);
    @(posedge clk_sys);
    areq <= 1'b1;
    ainstr <= instr;
    aset <= set;
    @(posedge clk_sys);
    areq <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK(adone, 1'b1)
  endtask
  task maint(input logic [1:0] op, input logic bg, v, d);
    @(posedge clk_sys);
    mreq <= 1'b1;
    mop <= op;
    mbg <= bg;
    lv <= v;
    ld <= d;
    @(posedge clk_sys);
    mreq <= 1'b0;
    #1;
  endtask
  // Bounded wait for an unlock-all to finish; a hang ends the run
  task wait_unlock;
    for (i = 0; i < 300 && busy; i++)
      @(posedge clk_sys) #1;
    if (busy) begin
      n_fail++;
      give_verdict();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Register permissions by security state and permit bit
  task t_access;
    `CHK(nsp, 1'b0)
    acc(1, 0, 12'h900, 16'h000f);
    `CHK(r, 2'h3)
    acc(1, 1, 12'h904, 16'h00aa);
    `CHK(r, 2'h0)
    acc(1, 0, 12'h904, 16'h0055);
    `CHK(r, 2'h3)
    acc(0, 0, 12'h904, 16'h0000);
    `CHK(r, 2'h0)
    `CHK(ok, 1'b1)
    `CHK(q, 16'h00aa)
    @(posedge clk_sys);
    pwe <= 1'b1;
    pval <= 1'b1;
    @(posedge clk_sys);
    pwe <= 1'b0;
    #1;
    `CHK(nsp, 1'b1)
    acc(1, 0, 12'h904, 16'h00fe);
    `CHK(r, 2'h0)
    acc(0, 1, 12'h904, 16'h0000);
    `CHK(q, 16'h00fe)
    acc(1, 1, 12'h908, 16'h00ff);
    acc(0, 1, 12'h908, 16'h0000);
    `CHK(q, 16'h0000)
  endtask
  // Unlock-all clears stale line locks; background work is refused meanwhile
  task t_unlock;
    acc(1, 1, 12'h954, 16'h00ff);
    `CHK(busy, 1'b1)
    maint(2'h2, 1, 1, 1);
    `CHK(mresp, 2'h2)
    wait_unlock();
  endtask
  // Way locks per class, then line locks filling one set
  task t_alloc;
    acc(1, 0, 12'h900, 16'h0001);
    for (int k = 0; k < 8; k++) begin
      alloc(0, 6'h01);
      `CHK(aok && away != 3'h0, 1'b1)
    end
    alloc(1, 6'h01);
    `CHK(away, 3'h0)
    acc(1, 1, 12'h900, 16'h00ff);
    alloc(0, 6'h02);
    `CHK(aok, 1'b0)
    acc(1, 1, 12'h900, 16'h0000);
    acc(1, 1, 12'h904, 16'h0000);
    acc(1, 1, 12'h950, 16'h0001);
    seen = 8'h00;
    for (int k = 0; k < 8; k++) begin
      alloc(0, 6'h09);
      `CHK(seen[away], 1'b0)
      seen[away] = 1'b1;
    end
    alloc(1, 6'h09);
    `CHK(aok, 1'b0)
    // Unlock-all frees the full set again
    acc(1, 1, 12'h954, 16'h00ff);
    wait_unlock();
    alloc(1, 6'h09);
    `CHK(aok, 1'b1)
  endtask
  // Clean, invalidate and clean-invalidate on valid clean and dirty lines; repeated invalidates are harmless
  task t_maint;
    // Every way locked: maintenance must act as on unlocked lines
    acc(1, 1, 12'h900, 16'h00ff);
    acc(1, 1, 12'h904, 16'h00ff);
    for (int op = 0; op < 3; op++)
      for (int d = 0; d < 2; d++) begin
        maint(op[1:0], 0, 1, d[0]);
        `CHK(wb, op != 1 && d == 1)
        `CHK({vo, dout}, {op == 0, 1'b0})
      end
    // Level-one clean and barrier_op run in the processor; only the
    // clean_inv_level_two step and its sync reach this block
    maint(2'h2, 0, 1, 1);
    `CHK({wb, vo, dout}, 3'h4)
    // invalidate_level_two around a level-one pass, done twice
    maint(2'h1, 0, 1, 1);
    `CHK(mdone && !vo, 1'b1)
    maint(2'h1, 0, 1, 0);
    `CHK({wb, vo, dout}, 3'h0)
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    {reset, pwe, pval, areq, ainstr, mreq, mbg, lv, ld} = 9'h100;
    aset = 6'h00;
    mop = 2'h3;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys) #1;
    t_access();
    t_unlock();
    t_alloc();
    t_maint();
    give_verdict();
  end
endmodule // tb
bind l2_lockdown_ctrl lockdown_checker chk (.*);
